//--- hw/fpcs_pkg.sv
// shared constants and types of the factory program command sequencer
// assumes 16-bit bus words, 21-bit word addresses, 8 banks of 8 blocks
package fpcs_pkg;
  localparam int ADDR_W     = 21;
  localparam int DATA_W     = 16;
  localparam int OP_W       = 3;
  localparam int BANK_LSB   = 18;
  localparam int BLOCK_LSB  = 15;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_W     = OP_W + ADDR_W + DATA_W;
  localparam int CNT_W      = 4;

  localparam logic [7:0] CMD_READ_ARRAY   = 8'hff;
  localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
  localparam logic [7:0] CMD_READ_SIG     = 8'h90;
  localparam logic [7:0] CMD_READ_QUERY   = 8'h98;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_BANK_ERASE   = 8'h80;
  localparam logic [7:0] CMD_CONFIRM      = 8'hd0;
  localparam logic [7:0] CMD_DOUBLE       = 8'h35;
  localparam logic [7:0] CMD_QUAD         = 8'h56;
  localparam logic [7:0] CMD_ENHANCED     = 8'h30;
  localparam logic [15:0] EXIT_WORD       = 16'hffff;

  localparam logic       FLAG_RST  = 1'b0;
  localparam logic       READY_RST = 1'b1;
  localparam logic [1:0] LEFT_DW   = 2'h1;
  localparam logic [1:0] LEFT_QW   = 2'h3;

  // engine operations carried with each fifo entry
  typedef enum logic [2:0] {
    OP_ERASE, OP_PROG, OP_START, OP_VERIFY, OP_PEND, OP_VEND, OP_ABORT
  } fpcs_op_type;

  typedef enum logic [1:0] {
    RM_ARRAY, RM_STATUS, RM_SIG, RM_QUERY
  } fpcs_rmode_type;
endpackage

//--- hw/fpcs_stream_if.sv
// valid/ready word stream between the sequencer and its fifo
// assumes both ends on the same clock
`timescale 1ns/100ps
interface fpcs_stream_if #(parameter int W = fpcs_pkg::FIFO_W);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

//--- hw/fpcs_fifo.sv
// word fifo with a registered output stage
// assumes one clock, synchronous active-low reset
`timescale 1ns/100ps
module fpcs_fifo #(
  parameter int WIDTH = fpcs_pkg::FIFO_W,
  parameter int DEPTH = fpcs_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // fill and drain sides
  fpcs_stream_if.snk in_s,
  fpcs_stream_if.src out_s
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0]    wr_ptr_reg;
  logic [PW-1:0]    rd_ptr_reg;
  logic [PW:0]      count_reg;
  logic             out_valid_reg;
  logic [WIDTH-1:0] out_data_reg;

  wire do_push = in_s.valid && in_s.ready;
  wire do_pop  = (count_reg != '0) && (!out_valid_reg || out_s.ready);

  // full only counts storage; output stage adds one spare word
  assign in_s.ready  = count_reg != (PW+1)'(DEPTH);
  assign out_s.valid = out_valid_reg;
  assign out_s.data  = out_data_reg;

  always_ff @(posedge clk_i) begin
    if (do_push) begin
      mem_reg[wr_ptr_reg] <= in_s.data;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_ptr_reg    <= '0;
      rd_ptr_reg    <= '0;
      count_reg     <= '0;
      out_valid_reg <= 1'b0;
      out_data_reg  <= '0;
    end else begin
      wr_ptr_reg <= do_push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
      rd_ptr_reg <= do_pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
      count_reg  <= count_reg + (PW+1)'(do_push) - (PW+1)'(do_pop);
      if (do_pop) begin
        out_valid_reg <= 1'b1;
        out_data_reg  <= mem_reg[rd_ptr_reg];
      end else if (out_s.ready) begin
        out_valid_reg <= 1'b0;
      end
    end
  end
endmodule

//--- hw/fpcs_sequencer.sv
// command sequencer for the factory program commands of one flash device
// assumes host bus pins asynchronous; engine signals on clk_i
`timescale 1ns/100ps
module fpcs_sequencer (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // host bus pins
  input  wire logic        host_write_i,
  input  wire logic [20:0] host_addr_i,
  input  wire logic [15:0] host_data_i,
  input  wire logic        vpp_high_i,
  // program/erase engine
  input  wire logic        eng_ready_i,
  input  wire logic        eng_done_i,
  input  wire logic        eng_fail_i,
  output logic             eng_valid_o,
  output logic [2:0]       eng_op_o,
  output logic [20:0]      eng_addr_o,
  output logic [15:0]      eng_data_o,
  // status
  output logic             controller_ready_bit_o,
  output logic             bank_write_status_bit_o,
  output logic             sequence_error_flag_a_o,
  output logic             sequence_error_flag_b_o,
  output logic             program_fail_o,
  output logic             vpp_low_error_o,
  output logic             status_read_o,
  output logic [1:0]       read_mode_o,
  output logic [2:0]       active_bank_o
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_ERASE_SETUP, ST_WORD_LOAD, ST_ENH_SETUP,
    ST_ENH_PROG, ST_ENH_VERIFY, ST_BUSY
  } fpcs_state_type;

  fpcs_state_type          state_reg, state_next;
  fpcs_pkg::fpcs_rmode_type rmode_reg, rmode_next;
  logic [1:0]  wr_sync_reg;
  logic        wr_prev_reg;
  logic [20:0] addr_s1_reg, addr_s2_reg;
  logic [15:0] data_s1_reg, data_s2_reg;
  logic [1:0]  vpp_sync_reg;
  logic [2:0]  bank_reg, bank_next;
  logic [20:0] start_reg, start_next;
  logic [20:0] ptr_reg, ptr_next;
  logic [1:0]  left_reg, left_next;
  logic        quad_reg, quad_next;
  logic        first_reg, first_next;
  logic        err_a_reg, err_a_next;
  logic        err_b_reg, err_b_next;
  logic        fail_reg, fail_next;
  logic        vpp_err_reg, vpp_err_next;
  logic        ready_reg, bws_reg, stat_reg;
  logic        push_valid;
  fpcs_pkg::fpcs_op_type push_op;
  logic [20:0] push_addr;
  logic        clr_flags;

  fpcs_stream_if #(.W(fpcs_pkg::FIFO_W)) push_s ();
  fpcs_stream_if #(.W(fpcs_pkg::FIFO_W)) eng_s ();

  // decode of the sampled bus write
  wire       wr_evt    = wr_sync_reg[1] && !wr_prev_reg;
  wire       vpp_ok    = vpp_sync_reg[1];
  wire [7:0] cmd       = data_s2_reg[7:0];
  wire [2:0] addr_bank = addr_s2_reg[20:fpcs_pkg::BANK_LSB];
  wire       same_bank = addr_bank == bank_reg;
  wire       in_block  = addr_s2_reg[20:fpcs_pkg::BLOCK_LSB]
                         == start_reg[20:fpcs_pkg::BLOCK_LSB];
  wire       is_exit   = !in_block && data_s2_reg == fpcs_pkg::EXIT_WORD;
  wire       is_read   = cmd == fpcs_pkg::CMD_READ_ARRAY
                         || cmd == fpcs_pkg::CMD_READ_STATUS
                         || cmd == fpcs_pkg::CMD_READ_SIG
                         || cmd == fpcs_pkg::CMD_READ_QUERY;
  wire fpcs_pkg::fpcs_rmode_type rmode_cmd =
      cmd == fpcs_pkg::CMD_READ_ARRAY  ? fpcs_pkg::RM_ARRAY :
      cmd == fpcs_pkg::CMD_READ_SIG    ? fpcs_pkg::RM_SIG   :
      cmd == fpcs_pkg::CMD_READ_QUERY  ? fpcs_pkg::RM_QUERY :
                                         fpcs_pkg::RM_STATUS;
  wire       is_prog   = cmd == fpcs_pkg::CMD_DOUBLE
                         || cmd == fpcs_pkg::CMD_QUAD
                         || cmd == fpcs_pkg::CMD_ENHANCED;
  // page words may differ only in the low address bits
  wire       page_ok   = quad_reg
                         ? addr_s2_reg[20:2] == start_reg[20:2]
                         : addr_s2_reg[20:1] == start_reg[20:1];
  wire       at_start  = addr_s2_reg == start_reg;
  wire [20:0] stream_addr = (first_reg || !at_start) ? addr_s2_reg
                                                     : ptr_reg;
  wire       can_push  = push_s.ready;
  wire       idle_like = state_next == ST_IDLE
                         || state_next == ST_ERASE_SETUP
                         || state_next == ST_ENH_SETUP
                         || state_next == ST_WORD_LOAD;
  wire       streaming = state_next == ST_ENH_PROG
                         || state_next == ST_ENH_VERIFY;

  assign push_s.valid = push_valid;
  assign push_s.data  = {push_op, push_addr, data_s2_reg};
  assign eng_s.ready  = eng_ready_i;

  fpcs_fifo #(
    .WIDTH (fpcs_pkg::FIFO_W),
    .DEPTH (fpcs_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .in_s    (push_s),
    .out_s   (eng_s)
  );

  always_comb begin
    state_next   = state_reg;
    rmode_next   = rmode_reg;
    bank_next    = bank_reg;
    start_next   = start_reg;
    ptr_next     = ptr_reg;
    left_next    = left_reg;
    quad_next    = quad_reg;
    first_next   = first_reg;
    err_a_next   = err_a_reg;
    err_b_next   = err_b_reg;
    vpp_err_next = vpp_err_reg;
    push_valid   = 1'b0;
    push_op      = fpcs_pkg::OP_PROG;
    push_addr    = addr_s2_reg;
    clr_flags    = 1'b0;
    case (state_reg)
      ST_IDLE: if (wr_evt) begin
        bank_next = addr_bank;
        if (is_read) begin
          rmode_next = rmode_cmd;
        end else if (cmd == fpcs_pkg::CMD_CLEAR_STATUS) begin
          clr_flags = 1'b1;
        end else if (cmd == fpcs_pkg::CMD_BANK_ERASE) begin
          // allowed at either program supply level
          state_next = ST_ERASE_SETUP;
        end else if (is_prog && !vpp_ok) begin
          vpp_err_next = 1'b1;
        end else if (cmd == fpcs_pkg::CMD_ENHANCED) begin
          state_next = ST_ENH_SETUP;
        end else if (is_prog) begin
          state_next = ST_WORD_LOAD;
          quad_next  = cmd == fpcs_pkg::CMD_QUAD;
          left_next  = cmd == fpcs_pkg::CMD_QUAD ? fpcs_pkg::LEFT_QW
                                                 : fpcs_pkg::LEFT_DW;
          first_next = 1'b1;
        end
      end
      ST_ERASE_SETUP, ST_ENH_SETUP: if (wr_evt) begin
        rmode_next = fpcs_pkg::RM_STATUS;
        first_next = 1'b1;
        if (cmd != fpcs_pkg::CMD_CONFIRM) begin
          err_a_next = 1'b1;
          err_b_next = 1'b1;
          state_next = ST_IDLE;
        end else if (state_reg == ST_ENH_SETUP) begin
          state_next = ST_ENH_PROG;
        end else begin
          // whole bank to ones, bank latched at the erase setup write
          push_valid = 1'b1;
          push_op    = fpcs_pkg::OP_ERASE;
          state_next = ST_BUSY;
        end
      end
      ST_WORD_LOAD: if (wr_evt) begin
        push_valid = 1'b1;
        first_next = 1'b0;
        left_next  = left_reg - 2'h1;
        if (first_reg) begin
          start_next = addr_s2_reg;
        end
        if (!first_reg && !page_ok) begin
          // stray page word: drop the whole group
          push_op    = fpcs_pkg::OP_ABORT;
          err_a_next = 1'b1;
          err_b_next = 1'b1;
          state_next = ST_IDLE;
        end else if (left_reg == 2'h0) begin
          push_op    = fpcs_pkg::OP_START;
          rmode_next = fpcs_pkg::RM_STATUS;
          state_next = ST_BUSY;
        end
      end
      ST_ENH_PROG, ST_ENH_VERIFY: if (wr_evt && can_push) begin
        // a word sent while the write status bit is high is lost
        if (!first_reg && !in_block && !is_exit) begin
          push_valid = 1'b0;
        end else if (!first_reg && is_exit) begin
          push_valid = 1'b1;
          first_next = 1'b1;
          if (state_reg == ST_ENH_PROG) begin
            push_op    = fpcs_pkg::OP_PEND;
            state_next = ST_ENH_VERIFY;
          end else begin
            push_op    = fpcs_pkg::OP_VEND;
            state_next = ST_BUSY;
          end
        end else begin
          push_valid = 1'b1;
          push_op    = state_reg == ST_ENH_VERIFY ? fpcs_pkg::OP_VERIFY
                                                  : fpcs_pkg::OP_PROG;
          push_addr  = stream_addr;
          ptr_next   = stream_addr + 21'h000001;
          first_next = 1'b0;
          if (first_reg && state_reg == ST_ENH_PROG) begin
            start_next = addr_s2_reg;
          end
        end
      end
      ST_BUSY: begin
        // only reads of the busy bank, no suspend, no other bank
        if (wr_evt && is_read && same_bank) begin
          rmode_next = rmode_cmd;
        end
        // all-protected bank ends with done and no error
        if (eng_done_i) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // fail is set by the engine; set wins over clear
  assign fail_next = (fail_reg && !clr_flags) || eng_fail_i;

  // pin synchronisers
  always_ff @(posedge clk_i) begin
    wr_sync_reg  <= {wr_sync_reg[0], host_write_i};
    wr_prev_reg  <= wr_sync_reg[1];
    addr_s1_reg  <= host_addr_i;
    addr_s2_reg  <= addr_s1_reg;
    data_s1_reg  <= host_data_i;
    data_s2_reg  <= data_s1_reg;
    vpp_sync_reg <= {vpp_sync_reg[0], vpp_high_i};
  end

  // reset abandons any erase or program in flight
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_reg   <= ST_IDLE;
      rmode_reg   <= fpcs_pkg::RM_ARRAY;
      bank_reg    <= '0;
      start_reg   <= '0;
      ptr_reg     <= '0;
      left_reg    <= '0;
      quad_reg    <= 1'b0;
      first_reg   <= 1'b1;
      err_a_reg   <= fpcs_pkg::FLAG_RST;
      err_b_reg   <= fpcs_pkg::FLAG_RST;
      fail_reg    <= fpcs_pkg::FLAG_RST;
      vpp_err_reg <= fpcs_pkg::FLAG_RST;
      ready_reg   <= fpcs_pkg::READY_RST;
      bws_reg     <= fpcs_pkg::FLAG_RST;
      stat_reg    <= fpcs_pkg::FLAG_RST;
    end else begin
      state_reg   <= state_next;
      rmode_reg   <= rmode_next;
      bank_reg    <= bank_next;
      start_reg   <= start_next;
      ptr_reg     <= ptr_next;
      left_reg    <= left_next;
      quad_reg    <= quad_next;
      first_reg   <= first_next;
      err_a_reg   <= err_a_next && !clr_flags;
      err_b_reg   <= err_b_next && !clr_flags;
      fail_reg    <= fail_next;
      vpp_err_reg <= vpp_err_next && !clr_flags;
      ready_reg   <= idle_like;
      bws_reg     <= !idle_like && !(streaming && push_s.ready);
      stat_reg    <= !idle_like || rmode_next == fpcs_pkg::RM_STATUS;
    end
  end

  assign controller_ready_bit_o  = ready_reg;
  assign bank_write_status_bit_o = bws_reg;
  assign sequence_error_flag_a_o = err_a_reg;
  assign sequence_error_flag_b_o = err_b_reg;
  assign program_fail_o          = fail_reg;
  assign vpp_low_error_o         = vpp_err_reg;
  assign status_read_o           = stat_reg;
  assign read_mode_o             = rmode_reg;
  assign active_bank_o           = bank_reg;
  assign eng_valid_o             = eng_s.valid;
  assign eng_op_o                = eng_s.data[39:37];
  assign eng_addr_o              = eng_s.data[36:16];
  assign eng_data_o              = eng_s.data[15:0];

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  AST_READY_LOW_BUSY: assert property (
    state_reg == ST_BUSY |-> !controller_ready_bit_o && status_read_o)
    else $error("ready bit high while engine busy");
  AST_ERASE_BAD_CONFIRM: assert property (
    state_reg == ST_ERASE_SETUP && wr_evt && cmd != fpcs_pkg::CMD_CONFIRM
    |=> sequence_error_flag_a_o && sequence_error_flag_b_o
        && state_reg == ST_IDLE)
    else $error("bad erase confirm not flagged");
  AST_ERASE_START: assert property (
    state_reg == ST_ERASE_SETUP && wr_evt && cmd == fpcs_pkg::CMD_CONFIRM
    |-> push_valid && push_op == fpcs_pkg::OP_ERASE
        ##1 state_reg == ST_BUSY ##1 !controller_ready_bit_o)
    else $error("erase not started");
  AST_BUSY_NO_PUSH: assert property (
    state_reg == ST_BUSY && wr_evt && !(is_read && same_bank)
    |-> !push_valid ##1 $stable(read_mode_o)
        && $stable(sequence_error_flag_a_o))
    else $error("command taken while busy");
  AST_VPP_REFUSE: assert property (
    state_reg == ST_IDLE && wr_evt && is_prog && !vpp_ok
    |=> state_reg == ST_IDLE && vpp_low_error_o)
    else $error("program command ran at low supply");
  AST_PROG_EXIT: assert property (
    state_reg == ST_ENH_PROG && wr_evt && can_push && !first_reg
    && is_exit |=> state_reg == ST_ENH_VERIFY && first_reg)
    else $error("program phase did not end");
  AST_OUTSIDE_IGNORED: assert property (
    state_reg == ST_ENH_PROG && wr_evt && !first_reg && !in_block
    && !is_exit |=> state_reg == ST_ENH_PROG && $stable(ptr_reg))
    else $error("outside write not ignored");
  AST_AUTO_INC: assert property (
    state_reg == ST_ENH_PROG && wr_evt && can_push && !first_reg
    && at_start |-> push_addr == ptr_reg
    ##1 ptr_reg == $past(ptr_reg) + 21'h000001)
    else $error("start address did not auto-increment");
  AST_DONE_READY: assert property (
    state_reg == ST_BUSY && eng_done_i
    |=> controller_ready_bit_o && state_reg == ST_IDLE)
    else $error("ready bit not set on exit");
  AST_FAIL_STICKY: assert property (
    eng_fail_i |=> program_fail_o)
    else $error("engine failure not flagged");
endmodule

//--- tb/fpcs_engine_model.sv
// behavioural program/erase engine facing the sequencer's fifo head
// assumes the sequencer clock and reset; tb steers stall and failure
`timescale 1ns/100ps
module fpcs_engine_model #(
  parameter int DLY = 60
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // fifo head from the sequencer
  input  wire logic        valid_i,
  input  wire logic [2:0]  op_i,
  input  wire logic [20:0] addr_i,
  input  wire logic [15:0] data_i,
  // bench controls
  input  wire logic        stall_i,
  input  wire logic        fail_en_i,
  // engine answers and last taken word
  output logic             ready_o,
  output logic             done_o,
  output logic             fail_o,
  output logic [7:0]       pops_o,
  output logic [2:0]       op_o,
  output logic [20:0]      addr_o,
  output logic [15:0]      data_o
);
  int   cnt;
  logic take;

  // locking is not modelled: the bench aims only at unlocked blocks
  assign ready_o = !stall_i;
  assign take    = valid_i && ready_o;

  always_ff @(posedge clk_i) begin
    done_o <= 1'b0;
    fail_o <= 1'b0;
    if (!rst_n_i) begin
      pops_o <= 8'h00;
      op_o   <= 3'h0;
      addr_o <= 21'h000000;
      data_o <= 16'h0000;
      cnt    <= 0;
    end else if (take) begin
      pops_o <= pops_o + 8'h01;
      op_o   <= op_i;
      addr_o <= addr_i;
      data_o <= data_i;
      // only erase, page start and verify end keep the engine busy
      if (op_i == fpcs_pkg::OP_ERASE || op_i == fpcs_pkg::OP_START ||
          op_i == fpcs_pkg::OP_VEND) begin
        cnt <= DLY;
      end
    end else if (cnt == 1) begin
      // protected blocks just finish quietly
      done_o <= 1'b1;
      // reprogram failure only reported at verify end
      fail_o <= fail_en_i && op_o == fpcs_pkg::OP_VEND;
      cnt    <= 0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule

//--- tb/tb.sv
// self-checking bench of the factory program command sequencer
// assumes the engine model in its own file; writes kept slow and spaced
`timescale 1ns/100ps
module tb;
  logic        clk, rst_n, wr_s, vpp, stall, fail_en;
  logic [20:0] addr, e_addr, m_addr;
  logic [15:0] data, e_data, m_data;
  logic        e_rdy, e_done, e_fail, e_val;
  logic [2:0]  e_op, bank, m_op;
  logic        rdy, bws, fa, fb, pf, vle, sr;
  logic [1:0]  rm;
  logic [7:0]  pops, p0;
  int          err_count, cmp_count;
  localparam logic [20:0] S   = 21'h0c8000;
  localparam logic [20:0] OUT = 21'h000010;

  fpcs_sequencer DUT (.clk_i(clk), .rst_n_i(rst_n), .host_write_i(wr_s),
    .host_addr_i(addr), .host_data_i(data), .vpp_high_i(vpp),
    .eng_ready_i(e_rdy), .eng_done_i(e_done), .eng_fail_i(e_fail),
    .eng_valid_o(e_val), .eng_op_o(e_op), .eng_addr_o(e_addr),
    .eng_data_o(e_data), .controller_ready_bit_o(rdy),
    .bank_write_status_bit_o(bws), .sequence_error_flag_a_o(fa),
    .sequence_error_flag_b_o(fb), .program_fail_o(pf),
    .vpp_low_error_o(vle), .status_read_o(sr), .read_mode_o(rm),
    .active_bank_o(bank));

  fpcs_engine_model eng (.clk_i(clk), .rst_n_i(rst_n), .valid_i(e_val),
    .op_i(e_op), .addr_i(e_addr), .data_i(e_data), .stall_i(stall),
    .fail_en_i(fail_en), .ready_o(e_rdy), .done_o(e_done),
    .fail_o(e_fail), .pops_o(pops), .op_o(m_op), .addr_o(m_addr),
    .data_o(m_data));

  always #20 clk = ~clk;

  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task chk(input logic [47:0] got, input logic [47:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task test_done;
    $display("errors %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // address and data settle 3 clocks ahead, strobe gaps stay long
  task wr(input logic [20:0] a, input logic [15:0] d);
    addr = a;
    data = d;
    cyc(3);
    wr_s = 1'b1;
    cyc(2);
    wr_s = 1'b0;
    cyc(5);
  endtask

  task ew(input logic [20:0] a, input logic [15:0] d);
    int i;
    for (i = 0; i < 200 && bws !== 1'b0; i++) cyc(1);
    chk(bws, 1'b0, "word accept");
    wr(a, d);
  endtask

  task wait_rdy;
    int i;
    for (i = 0; i < 300 && rdy !== 1'b1; i++) cyc(1);
    chk(rdy, 1'b1, "ready");
  endtask

  task t_erase;
    vpp = 1'b0;
    p0 = pops;
    wr(S, 16'h0080); // single erase of this bank, far below limit
    wr(S, 16'h00d0);
    chk({rdy, bws, sr, bank}, {3'b011, 3'h3}, "erase busy");
    wr(S, 16'h0035);
    wr(OUT, 16'h0098);
    chk({rm, vle}, {fpcs_pkg::RM_STATUS, 1'b0}, "other bank");
    wr(S, 16'h0090);
    chk(rm, fpcs_pkg::RM_SIG, "busy read cmd");
    wr(S, 16'h0070);
    wait_rdy();
    chk({pops - p0, m_op, sr}, {8'h01, fpcs_pkg::OP_ERASE, 1'b1},
        "er");
    wr(S, 16'h0098);
    chk({sr, rm}, {1'b0, fpcs_pkg::RM_QUERY}, "read query");
    wr(S, 16'h00ff);
    chk({sr, rm}, {1'b0, fpcs_pkg::RM_ARRAY}, "read array");
    vpp = 1'b1;
  endtask

  task t_badconf;
    wr(S, 16'h0080);
    wr(S, 16'h0012);
    chk({fa, fb, rdy}, 3'b111, "bad confirm");
    wr(S, 16'h0050);
    chk({fa, fb}, 2'b00, "clear");
  endtask

  task t_double;
    p0 = pops;
    wr(S, 16'h0035);
    wr(S + 21'h10, 16'h1111);
    wr(S + 21'h11, 16'h2222);
    chk({rdy, sr}, 2'b01, "dw busy");
    wait_rdy();
    chk({pops - p0, m_op, m_addr, m_data},
        {8'h02, fpcs_pkg::OP_START, S + 21'h11, 16'h2222}, "dw");
    wr(S, 16'h0035);
    wr(S + 21'h10, 16'h1111);
    wr(S + 21'h12, 16'h2222);
    chk({fa, fb, m_op}, {2'b11, fpcs_pkg::OP_ABORT}, "dw page");
    wr(S, 16'h0050);
  endtask

  task t_quad;
    int i;
    p0 = pops;
    wr(S, 16'h0056);
    for (i = 0; i < 4; i++) wr(S + 21'h20 + 21'(i), 16'h4440 + 16'(i));
    chk(rdy, 1'b0, "qw busy");
    wait_rdy();
    chk({pops - p0, m_op, m_addr, m_data},
        {8'h04, fpcs_pkg::OP_START, S + 21'h23, 16'h4443}, "qw");
  endtask

  task t_enh;
    fail_en = 1'b1;
    p0 = pops;
    wr(S, 16'h0030); // block sees two enhanced runs only
    wr(S, 16'h00d0);
    chk({rdy, sr, bws}, 3'b010, "enh setup");
    ew(S, 16'h1111);
    chk({m_op, m_addr}, {fpcs_pkg::OP_PROG, S}, "first word");
    ew(S, 16'h2222);
    chk(m_addr, S + 21'h1, "auto increment");
    ew(S + 21'h5, 16'h3333);
    chk(m_addr, S + 21'h5, "jump");
    ew(OUT, 16'h1234);
    chk(pops - p0, 8'h03, "outside ignored");
    ew(OUT, 16'hffff);
    chk(m_op, fpcs_pkg::OP_PEND, "program end");
    ew(S, 16'h1111);
    ew(S, 16'h2222);
    chk({m_op, m_data}, {fpcs_pkg::OP_VERIFY, 16'h2222}, "verify");
    ew(S + 21'h5, 16'h3333);
    ew(OUT, 16'hffff);
    chk({m_op, rdy}, {fpcs_pkg::OP_VEND, 1'b0}, "verify end");
    wait_rdy();
    chk({pf, sr}, 2'b11, "fail flagged");
    fail_en = 1'b0;
    wr(S, 16'h0050);
    chk(pf, 1'b0, "fail cleared");
  endtask

  task t_fill;
    int i;
    vpp = 1'b0;
    wr(S, 16'h0035);
    chk(vle, 1'b1, "low supply");
    vpp = 1'b1;
    stall = 1'b1;
    wr(S, 16'h0030);
    wr(S, 16'h00d0);
    for (i = 0; i < 9; i++) wr(S, 16'h0a00 + 16'(i));
    chk(bws, 1'b1, "fifo full");
    stall = 1'b0;
    cyc(20);
    chk({bws, e_val}, 2'b00, "drained");
    stall = 1'b1;
    wr(S, 16'h0077);
    rst_n = 1'b0;
    cyc(4);
    rst_n = 1'b1;
    cyc(1);
    chk({rdy, e_val, vle, bws}, 4'b1000, "reset abort");
    stall = 1'b0;
    p0 = pops;
    cyc(10);
    chk(pops - p0, 8'h00, "nothing left");
  endtask

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    wr_s = 1'b0;
    vpp = 1'b1;
    stall = 1'b0;
    fail_en = 1'b0;
    addr = 21'h000000;
    data = 16'h0000;
    err_count = 0;
    cmp_count = 0;
    cyc(6);
    rst_n = 1'b1;
    cyc(1);
    chk({rdy, bws, fa, fb, pf, vle, sr, rm, e_val}, 10'h200,
        "reset");
    cyc(2);
    t_erase();
    t_badconf();
    t_double();
    t_quad();
    t_enh();
    t_fill();
    test_done();
  end

  initial begin
    #400000;
    err_count++;
    $display("FAIL %0t watchdog expired", $time);
    test_done();
  end
endmodule
